// *** hdl/lcc_pkg.sv ***
// constants and types shared by the loop compensation register block
// Functional notes
// - integrator gain code in bits 7:6
// - integrator time constant code in bits 5:3
// - ramp amplitude code in bits 2:0
// - integrator register holds three read/write fields
// - alternate registers stored, readable, drive nothing
// - alternate gain code in bits 7:4
// - alternate load-line code in bits 3:0
// - alternate integrator register mirrors main layout
// - loop options register holds four fields
// - light-load bit forces discontinuous during ramp only
// - on-time select steers negative-current high-side time
// - loop options bit 7 reads zero, read-only
// - bit clear: ramp mode follows forced-continuous setting
// - inductor select bits 4:3, 100-400nH
// - static load line bits 2:0, 0-4.05 milliohm
package lcc_pkg;
    localparam logic [7:0] OFS_INTEGRATOR_RAMP_CONFIG    = 8'haa;
    localparam logic [7:0] OFS_ALTERNATE_GAIN_LOADLINE   = 8'hab;
    localparam logic [7:0] OFS_ALTERNATE_INTEGRATOR_RAMP = 8'hac;
    localparam logic [7:0] OFS_LOOP_OPTIONS              = 8'had;

    // integrator / ramp layout, shared by main and alternate copies
    localparam int INT_GAIN_MSB  = 7;
    localparam int INT_GAIN_LSB  = 6;
    localparam int INT_TIME_MSB  = 5;
    localparam int INT_TIME_LSB  = 3;
    localparam int RAMP_MSB      = 2;
    localparam int RAMP_LSB      = 0;
    // alternate gain / load-line layout
    localparam int ALT_GAIN_MSB  = 7;
    localparam int ALT_GAIN_LSB  = 4;
    localparam int ALT_LL_MSB    = 3;
    localparam int ALT_LL_LSB    = 0;
    // loop options layout
    localparam int OPT_RESERVED  = 7;
    localparam int OPT_SS_DCM    = 6;
    localparam int OPT_NOC_TON   = 5;
    localparam int IND_SEL_MSB   = 4;
    localparam int IND_SEL_LSB   = 3;
    localparam int SLL_MSB       = 2;
    localparam int SLL_LSB       = 0;
    localparam logic [7:0] OPT_WRITE_MASK = 8'h7f;

    // power-up contents stand in for the nonvolatile copy
    localparam logic [7:0] RST_INTEGRATOR_RAMP_CONFIG    = 8'h00;
    localparam logic [7:0] RST_ALTERNATE_GAIN_LOADLINE   = 8'h00;
    localparam logic [7:0] RST_ALTERNATE_INTEGRATOR_RAMP = 8'h00;
    localparam logic [7:0] RST_LOOP_OPTIONS              = 8'h00;

    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;
    localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

    typedef enum logic [8:0] {
        ST_IDLE      = 9'b000000001,
        ST_ADDR      = 9'b000000010,
        ST_ADDR_ACK  = 9'b000000100,
        ST_CMD       = 9'b000001000,
        ST_CMD_ACK   = 9'b000010000,
        ST_WDATA     = 9'b000100000,
        ST_WDATA_ACK = 9'b001000000,
        ST_RDATA     = 9'b010000000,
        ST_RDATA_ACK = 9'b100000000
    } lcc_state_t;
endpackage

// *** hdl/lcc_reg_bank.sv ***
// the four byte-wide loop compensation registers
`timescale 1ns/1ps
module lcc_reg_bank (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] regAddr,
    input  wire logic       wrEn,
    input  wire logic [7:0] wrData,
    output logic      [7:0] rdData,
    output logic            regHit,
    output logic      [7:0] integratorRamp,
    output logic      [7:0] loopOptions
);
    import lcc_pkg::*;

    logic [7:0] intRamp_r, intRamp_nxt;
    logic [7:0] altGainLl_r, altGainLl_nxt;
    logic [7:0] altIntRamp_r, altIntRamp_nxt;
    logic [7:0] loopOpt_r, loopOpt_nxt;

    always_comb begin
        intRamp_nxt    = intRamp_r;
        altGainLl_nxt  = altGainLl_r;
        altIntRamp_nxt = altIntRamp_r;
        loopOpt_nxt    = loopOpt_r;
        rdData         = 8'h00;
        regHit         = 1'b1;
        case (regAddr)
            OFS_INTEGRATOR_RAMP_CONFIG: begin
                rdData = intRamp_r;
                if (wrEn) begin
                    intRamp_nxt = wrData;
                end
            end
            OFS_ALTERNATE_GAIN_LOADLINE: begin
                rdData = altGainLl_r;
                if (wrEn) begin
                    altGainLl_nxt = wrData;
                end
            end
            OFS_ALTERNATE_INTEGRATOR_RAMP: begin
                rdData = altIntRamp_r;
                if (wrEn) begin
                    altIntRamp_nxt = wrData;
                end
            end
            OFS_LOOP_OPTIONS: begin
                rdData = loopOpt_r & OPT_WRITE_MASK;
                if (wrEn) begin
                    loopOpt_nxt = wrData & OPT_WRITE_MASK;
                end
            end
            default: begin
                regHit = 1'b0;
            end
        endcase
    end

    // alternate copies end here on purpose: they feed no loop output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intRamp_r    <= RST_INTEGRATOR_RAMP_CONFIG;
            altGainLl_r  <= RST_ALTERNATE_GAIN_LOADLINE;
            altIntRamp_r <= RST_ALTERNATE_INTEGRATOR_RAMP;
            loopOpt_r    <= RST_LOOP_OPTIONS;
        end else begin
            intRamp_r    <= intRamp_nxt;
            altGainLl_r  <= altGainLl_nxt;
            altIntRamp_r <= altIntRamp_nxt;
            loopOpt_r    <= loopOpt_nxt;
        end
    end

    assign integratorRamp = intRamp_r;
    assign loopOptions    = loopOpt_r;
endmodule

// *** hdl/lcc_top.sv ***
// byte-wide two-wire serial slave and loop compensation settings
`timescale 1ns/1ps
module lcc_top #(
    parameter logic [6:0] DEV_ADDR = lcc_pkg::DEV_ADDR_DEFAULT
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    input  wire logic       softStartActive,
    input  wire logic       forcedContinuousConduction,
    output logic      [1:0] integratorGain,
    output logic      [2:0] integratorTime,
    output logic      [2:0] rampAmplitude,
    output logic            discontinuousConduction,
    output logic            negativeCurrentOnTimeSelect,
    output logic      [1:0] inductorValueSelect,
    output logic      [2:0] staticLoadLine
);
    import lcc_pkg::*;

    lcc_state_t state_r, state_nxt;
    logic [3:0] bitCnt_r, bitCnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic [7:0] txByte_r, txByte_nxt;
    logic       sdaOe_r, sdaOe_nxt;
    logic       rdMode_r, rdMode_nxt;
    logic       masterAck_r, masterAck_nxt;
    logic       sclPrev_r, sdaPrev_r;

    logic       sclRise, sclFall, startCond, stopCond;
    logic       wrEn;
    logic [7:0] wrData;
    logic [7:0] bankAddr;
    logic [7:0] rdData;
    logic       regHit;
    logic [7:0] integratorRamp;
    logic [7:0] loopOptions;

    // pins arrive already synchronous, so one history stage suffices
    assign sclRise   = sclIn & ~sclPrev_r;
    assign sclFall   = ~sclIn & sclPrev_r;
    assign startCond = sclIn & sclPrev_r & sdaPrev_r & ~sdaIn;
    assign stopCond  = sclIn & sclPrev_r & ~sdaPrev_r & sdaIn;

    // command byte is checked against the map before it is latched
    assign bankAddr = (state_r == ST_CMD) ? shift_r : cmd_r;

    lcc_reg_bank u_bank (
        .clk            (clk),
        .rst_n          (rst_n),
        .regAddr        (bankAddr),
        .wrEn           (wrEn),
        .wrData         (wrData),
        .rdData         (rdData),
        .regHit         (regHit),
        .integratorRamp (integratorRamp),
        .loopOptions    (loopOptions)
    );

    always_comb begin
        state_nxt     = state_r;
        bitCnt_nxt    = bitCnt_r;
        shift_nxt     = shift_r;
        cmd_nxt       = cmd_r;
        txByte_nxt    = txByte_r;
        sdaOe_nxt     = sdaOe_r;
        rdMode_nxt    = rdMode_r;
        masterAck_nxt = masterAck_r;
        wrEn          = 1'b0;
        wrData        = shift_r;
        if (startCond) begin
            // repeated start keeps the latched command for a read
            state_nxt  = ST_ADDR;
            bitCnt_nxt = 4'h0;
            sdaOe_nxt  = 1'b0;
        end else if (stopCond) begin
            state_nxt = ST_IDLE;
            sdaOe_nxt = 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    sdaOe_nxt = 1'b0;
                end
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    if (sclRise && bitCnt_r < BITS_PER_BYTE) begin
                        shift_nxt  = {shift_r[6:0], sdaIn};
                        bitCnt_nxt = bitCnt_r + 4'h1;
                    end else if (sclFall && bitCnt_r == BITS_PER_BYTE) begin
                        case (state_r)
                            ST_ADDR: begin
                                if (shift_r[7:1] == DEV_ADDR) begin
                                    state_nxt  = ST_ADDR_ACK;
                                    sdaOe_nxt  = 1'b1;
                                    rdMode_nxt = shift_r[0];
                                    txByte_nxt = rdData;
                                end else begin
                                    state_nxt = ST_IDLE;
                                end
                            end
                            ST_CMD: begin
                                // unmapped command is refused with a nack
                                if (regHit) begin
                                    cmd_nxt   = shift_r;
                                    state_nxt = ST_CMD_ACK;
                                    sdaOe_nxt = 1'b1;
                                end else begin
                                    state_nxt = ST_IDLE;
                                end
                            end
                            default: begin
                                wrEn      = 1'b1;
                                state_nxt = ST_WDATA_ACK;
                                sdaOe_nxt = 1'b1;
                            end
                        endcase
                    end
                end
                ST_ADDR_ACK: begin
                    if (sclFall) begin
                        bitCnt_nxt = 4'h0;
                        if (rdMode_r) begin
                            state_nxt = ST_RDATA;
                            sdaOe_nxt = ~txByte_r[7];
                        end else begin
                            state_nxt = ST_CMD;
                            sdaOe_nxt = 1'b0;
                        end
                    end
                end
                ST_CMD_ACK, ST_WDATA_ACK: begin
                    // further bytes overwrite the same register
                    if (sclFall) begin
                        state_nxt  = ST_WDATA;
                        bitCnt_nxt = 4'h0;
                        sdaOe_nxt  = 1'b0;
                    end
                end
                ST_RDATA: begin
                    if (sclRise && bitCnt_r < BITS_PER_BYTE) begin
                        bitCnt_nxt = bitCnt_r + 4'h1;
                    end else if (sclFall) begin
                        if (bitCnt_r == BITS_PER_BYTE) begin
                            state_nxt = ST_RDATA_ACK;
                            sdaOe_nxt = 1'b0;
                        end else begin
                            txByte_nxt = {txByte_r[6:0], 1'b0};
                            sdaOe_nxt  = ~txByte_r[6];
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    if (sclRise) begin
                        masterAck_nxt = ~sdaIn;
                    end else if (sclFall) begin
                        bitCnt_nxt = 4'h0;
                        if (masterAck_r) begin
                            state_nxt  = ST_RDATA;
                            txByte_nxt = rdData;
                            sdaOe_nxt  = ~rdData[7];
                        end else begin
                            state_nxt = ST_IDLE;
                            sdaOe_nxt = 1'b0;
                        end
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                    sdaOe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= ST_IDLE;
            bitCnt_r    <= 4'h0;
            shift_r     <= 8'h00;
            cmd_r       <= 8'h00;
            txByte_r    <= 8'h00;
            sdaOe_r     <= 1'b0;
            rdMode_r    <= 1'b0;
            masterAck_r <= 1'b0;
            sclPrev_r   <= 1'b1;
            sdaPrev_r   <= 1'b1;
        end else begin
            state_r     <= state_nxt;
            bitCnt_r    <= bitCnt_nxt;
            shift_r     <= shift_nxt;
            cmd_r       <= cmd_nxt;
            txByte_r    <= txByte_nxt;
            sdaOe_r     <= sdaOe_nxt;
            rdMode_r    <= rdMode_nxt;
            masterAck_r <= masterAck_nxt;
            sclPrev_r   <= sclIn;
            sdaPrev_r   <= sdaIn;
        end
    end

    // open drain: only ever pulls low
    assign sdaOut = 1'b0;
    assign sdaOe  = sdaOe_r;

    logic dcm_r, dcm_nxt;

    always_comb begin
        if (softStartActive && loopOptions[OPT_SS_DCM]) begin
            dcm_nxt = 1'b1;
        end else begin
            dcm_nxt = ~forcedContinuousConduction;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dcm_r <= 1'b0;
        end else begin
            dcm_r <= dcm_nxt;
        end
    end

    // field outputs come straight from the register flops, except conduction mode, which comes from its own flop dcm_r
    assign integratorGain              = integratorRamp[INT_GAIN_MSB:INT_GAIN_LSB];
    assign integratorTime              = integratorRamp[INT_TIME_MSB:INT_TIME_LSB];
    assign rampAmplitude               = integratorRamp[RAMP_MSB:RAMP_LSB];
    assign discontinuousConduction     = dcm_r;
    assign negativeCurrentOnTimeSelect = loopOptions[OPT_NOC_TON];
    assign inductorValueSelect         = loopOptions[IND_SEL_MSB:IND_SEL_LSB];
    assign staticLoadLine              = loopOptions[SLL_MSB:SLL_LSB];
endmodule

// *** testbench/lcc_top_sva.sv ***
// assertions on the pins of the loop compensation block
`timescale 1ns/1ps
module lcc_top_sva (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       sclIn,
    input wire logic       sdaIn,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic       softStartActive,
    input wire logic       forcedContinuousConduction,
    input wire logic [1:0] integratorGain,
    input wire logic [2:0] integratorTime,
    input wire logic [2:0] rampAmplitude,
    input wire logic       discontinuousConduction,
    input wire logic       negativeCurrentOnTimeSelect,
    input wire logic [1:0] inductorValueSelect,
    input wire logic [2:0] staticLoadLine
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // changes only while scl low, else a false start or stop
    sequence sclLow;
        !$past(sclIn) && !sclIn;
    endsequence
    sequence ackSoon;
        ##[0:3] sdaOe;
    endsequence
    a_sda_low_only: assert property (sdaOut == 1'b0)
        else $error("data pin driven high");
    a_mode_after_ramp: assert property (
        $past(rst_n) && !$past(softStartActive) |-> discontinuousConduction == !$past(forcedContinuousConduction))
        else $error("conduction mode outside ramp wrong");
    a_mode_not_forced: assert property (
        $past(rst_n) && !$past(forcedContinuousConduction) |-> discontinuousConduction)
        else $error("conduction mode not discontinuous");
    a_oe_scl_low: assert property ($changed(sdaOe) |-> sclLow)
        else $error("data pin moved with scl high");
    a_main_on_write: assert property (
        !$stable({integratorGain, integratorTime, rampAmplitude}) |-> sclLow ##0 ackSoon)
        else $error("main fields changed outside a write");
    a_opts_on_write: assert property (
        !$stable({negativeCurrentOnTimeSelect, inductorValueSelect, staticLoadLine}) |-> sclLow ##0 ackSoon)
        else $error("option fields changed outside a write");
    a_oe_holds: assert property ($rose(sdaOe) |-> sdaOe [*4])
        else $error("data pin pull too short");
    a_reset_quiet: assert property ($rose(rst_n) |-> !sdaOe && !discontinuousConduction
        && {integratorGain, integratorTime, rampAmplitude, inductorValueSelect, staticLoadLine} == 13'h0)
        else $error("outputs not idle after reset");
endmodule

// *** testbench/lcc_tb_top.sv ***
// self-checking bench for the loop compensation register block
`timescale 1ns/1ps
module lcc_tb_top;
    import lcc_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        sclIn = 1'b1;
    logic        mSda = 1'b1;
    logic        softStartActive = 1'b0;
    logic        forcedContinuousConduction = 1'b0;
    wire         sdaIn;
    logic        sdaOut, sdaOe, discontinuousConduction, negativeCurrentOnTimeSelect;
    logic [1:0]  integratorGain, inductorValueSelect;
    logic [2:0]  integratorTime, rampAmplitude, staticLoadLine;
    logic [7:0]  mdl [4];
    logic [31:0] seed = 32'd28263;
    int          error_cnt = 0;
    int          checked = 0;
    int          cyc = 0;
    // pull-up on the data line, either party pulls low
    assign sdaIn = mSda & ~sdaOe;
    lcc_top lcc_top_i (.clk(clk), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .softStartActive(softStartActive), .forcedContinuousConduction(forcedContinuousConduction),
        .integratorGain(integratorGain), .integratorTime(integratorTime), .rampAmplitude(rampAmplitude),
        .discontinuousConduction(discontinuousConduction), .negativeCurrentOnTimeSelect(negativeCurrentOnTimeSelect),
        .inductorValueSelect(inductorValueSelect), .staticLoadLine(staticLoadLine));
    initial begin
        forever #2.5 clk = ~clk;
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic xbit(input logic b, output logic r);
        mSda = b;
        tick(2);
        sclIn = 1'b1;
        tick(4);
        r = sdaIn;
        sclIn = 1'b0;
        tick(2);
    endtask
    task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] r, output logic nine);
        for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
        xbit(last, nine);
    endtask
    // serves as first and repeated start alike
    task automatic start();
        mSda = 1'b1;
        tick(2);
        sclIn = 1'b1;
        tick(4);
        mSda = 1'b0;
        tick(4);
        sclIn = 1'b0;
        tick(2);
    endtask
    task automatic stop();
        mSda = 1'b0;
        tick(2);
        sclIn = 1'b1;
        tick(4);
        mSda = 1'b1;
        tick(4);
    endtask
    task automatic outs();
        chk("main fields", {integratorGain, integratorTime, rampAmplitude}, mdl[0]);
        chk("option fields", {2'b0, negativeCurrentOnTimeSelect, inductorValueSelect, staticLoadLine},
            {2'b0, mdl[3][5:0]});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input int n);
        logic [7:0] r;
        logic       nk;
        logic       hit;
        hit = (a >= OFS_INTEGRATOR_RAMP_CONFIG) && (a <= OFS_LOOP_OPTIONS);
        start();
        xbyte({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, r, nk);
        chk("addr ack", {7'h0, nk}, 8'h00);
        xbyte(a, 1'b1, r, nk);
        chk("cmd ack", {7'h0, nk}, {7'h0, !hit});
        // extra bytes land in the same register
        for (int i = 0; i < n && hit; i++) begin
            xbyte(d ^ i[7:0], 1'b1, r, nk);
            chk("data ack", {7'h0, nk}, 8'h00);
        end
        if (hit) mdl[2'(a - OFS_INTEGRATOR_RAMP_CONFIG)] = (d ^ 8'(n - 1)) & (a == OFS_LOOP_OPTIONS ? 8'h7f : 8'hff);
        outs();
        stop();
    endtask
    task automatic rd(input logic [7:0] a);
        logic [7:0] r;
        logic       nk;
        logic [1:0] j;
        j = 2'(a - OFS_INTEGRATOR_RAMP_CONFIG);
        start();
        xbyte({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, r, nk);
        xbyte(a, 1'b1, r, nk);
        start();
        xbyte({DEV_ADDR_DEFAULT, 1'b1}, 1'b1, r, nk);
        chk("read addr ack", {7'h0, nk}, 8'h00);
        xbyte(8'hff, 1'b0, r, nk);
        chk("read data", r, mdl[j]);
        xbyte(8'hff, 1'b1, r, nk);
        chk("reread data", r, mdl[j]);
        stop();
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        logic [7:0] r;
        logic       nk;
        for (int i = 0; i < 4; i++) mdl[i] = 8'h00;
        tick(6);
        rst_n = 1'b1;
        tick(3);
        for (int i = 0; i < 4; i++) rd(OFS_INTEGRATOR_RAMP_CONFIG + i[7:0]);
        $display("test reset contents done");
        for (int k = 0; k < 12; k++) begin
            for (int i = 0; i < 4; i++) begin
                r = rnd();
                if (i == 1 && r[7:6] == 2'b11) r[7] = 1'b0; // host stays off reserved gain codes
                wr(OFS_INTEGRATOR_RAMP_CONFIG + i[7:0], r, 1 + k % 2);
                rd(OFS_INTEGRATOR_RAMP_CONFIG + i[7:0]);
            end
        end
        $display("test random traffic done");
        wr(8'ha9, 8'h5a, 1);
        wr(8'hae, 8'ha5, 1);
        start();
        xbyte({~DEV_ADDR_DEFAULT, 1'b0}, 1'b1, r, nk);
        chk("foreign addr nack", {7'h0, nk}, 8'h01);
        stop();
        rd(OFS_LOOP_OPTIONS);
        $display("test refusals done");
        // host setups: low output with a big inductor, then big ripple
        wr(OFS_LOOP_OPTIONS, 8'h1a, 1);
        rd(OFS_LOOP_OPTIONS);
        wr(OFS_LOOP_OPTIONS, 8'h29, 1);
        rd(OFS_LOOP_OPTIONS);
        $display("test host setups done");
        for (int k = 0; k < 8; k++) begin
            wr(OFS_LOOP_OPTIONS, {1'b1, k[2], mdl[3][5:0]}, 1);
            softStartActive = k[1];
            forcedContinuousConduction = k[0];
            tick(2);
            chk("conduction mode", {7'h0, discontinuousConduction}, {7'h0, (k[1] & k[2]) | !k[0]});
        end
        $display("test conduction mode done");
        rst_n = 1'b0;
        tick(6);
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++) mdl[i] = 8'h00;
        tick(3);
        rd(OFS_ALTERNATE_GAIN_LOADLINE);
        outs();
        $display("test second reset done");
        end_sim();
    end
endmodule
bind lcc_top lcc_top_sva lcc_top_sva_i (.clk(clk), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .softStartActive(softStartActive), .forcedContinuousConduction(forcedContinuousConduction),
    .integratorGain(integratorGain), .integratorTime(integratorTime), .rampAmplitude(rampAmplitude),
    .discontinuousConduction(discontinuousConduction), .negativeCurrentOnTimeSelect(negativeCurrentOnTimeSelect),
    .inductorValueSelect(inductorValueSelect), .staticLoadLine(staticLoadLine));
